// ==== logic/q15_mac_pkg.sv ====
// q15_mac_pkg: shared constants, types and arithmetic helpers for the
// fractional multiply-accumulate unit.
// assumes a 32-bit apb slave with byte addresses in the low eight bits.
package q15_mac_pkg;

	// apb register map, byte addresses
	localparam logic [7:0] CMD_OFF         = 8'h00; // command, a write launches an operation
	localparam logic [7:0] OPERAND_ONE_OFF = 8'h04; // first source operand
	localparam logic [7:0] OPERAND_TWO_OFF = 8'h08; // second source operand
	localparam logic [7:0] RESULT_OFF      = 8'h0c; // destination word of accumulator reads
	localparam logic [7:0] SPCTRL_OFF      = 8'h10; // signal_proc_control, read only
	localparam logic [7:0] CONFIG_OFF      = 8'h14; // dsp enable and isa_revision_field
	localparam logic [7:0] STATUS_OFF      = 8'h18; // sticky events, cleared by a read
	localparam logic [7:0] MASK_OFF        = 8'h1c; // interrupt mask, same layout

	// command field layout
	localparam int CMD_IDX_LSB  = 0; // sum_register_index, two bits
	localparam int CMD_SIDE_BIT = 2; // 0 left halfwords, 1 right halfwords
	localparam int CMD_MODE_BIT = 3; // 0 wrapping, 1 clamping
	localparam int CMD_KIND_LSB = 4; // operation group, two bits

	// config field layout
	localparam int CFG_EN_BIT  = 0; // dsp resources enabled
	localparam int CFG_REV_LSB = 1; // isa_revision_field, three bits

	// signal_proc_control layout
	localparam int OUFLAG_LSB = 16; // overflow_sticky_bits 19..16

	// status and mask bits
	localparam int ST_DONE    = 0; // an operation finished
	localparam int ST_OVF     = 1; // saturation or overflow happened
	localparam int ST_DSP_OFF = 2; // access check refused the operation
	localparam int ST_RSVD    = 3; // reserved operation group

	// numeric constants
	localparam logic [15:0] Q15_NEG_ONE   = 16'h8000;
	localparam logic [31:0] Q31_MAX       = 32'h7fffffff;
	localparam logic [31:0] Q31_MIN       = 32'h80000000;
	localparam logic [2:0]  REV_CHECK_MIN = 3'h2; // revision from which index-0 reads are checked; other indices always are
	localparam logic        CFG_EN_RST    = 1'h1; // dsp enabled out of reset
	localparam logic [2:0]  CFG_REV_RST   = 3'h0;

	// operation groups
	typedef enum logic [1:0] {
		K_MAC    = 2'b00, // q15_mult_{left,right}_{wrap,clamp}
		K_UPPER  = 2'b01, // read_upper_sum
		K_BOTTOM = 2'b10, // read_bottom_sum
		K_RSVD   = 2'b11  // reserved instruction
	} kind_e;

	// fractional_halfword_product: q15 x q15 into q31, with the -1 x -1 clamp
	function automatic logic [31:0] fractional_halfword_product(input logic [15:0] a,
		input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		if (a == Q15_NEG_ONE && b == Q15_NEG_ONE) begin
			return Q31_MAX;
		end
		return {p[30:0], 1'b0};
	endfunction : fractional_halfword_product

	// sign extension of a q31 word into a 64-bit accumulator value
	function automatic logic [63:0] sext64(input logic [31:0] v);
		return {{32{v[31]}}, v};
	endfunction : sext64

endpackage : q15_mac_pkg

// ==== logic/q15_fractional_mac_unit.sv ====
// q15_fractional_mac_unit: four 64-bit accumulators with q15 fractional
// multiply-accumulate, accumulator word reads and sticky overflow flags.
// assumes an apb master on pclk; operands and commands arrive as registers.
//
// Functional notes
// - left variants multiply upper halfwords, shift one
// - right variants multiply lower halfwords, shift one
// - both halfwords 0x8000 give 0x7fffffff product
// - wrapping adds sign-extended product, keeps 64 bits
// - clamping stores 0x7fffffff or 0x80000000 sign-extended
// - clamp when sum bit 32 differs bit 31
// - two-bit index selects one of four accumulators
// - saturation sets overflow bit 16 plus index
// - no data-dependent exceptions, flags only
// - access check precedes every multiply-accumulate
// - read_upper_sum copies accumulator bits 63..32
// - read_bottom_sum copies accumulator bits 31..0
// - reads stall until pending accumulate is written
`timescale 1ns/1ps
`default_nettype none

module q15_fractional_mac_unit
	import q15_mac_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq
);

	// datapath sequencer states
	typedef enum logic [1:0] {
		S_IDLE = 2'b00, // ready for a command
		S_MUL  = 2'b01, // product being formed
		S_ACC  = 2'b10  // accumulate pending, reads interlock
	} state_e;

	// every flip-flop of the block
	typedef struct packed {
		state_e          state;    // sequencer
		logic [3:0][63:0] acc;     // upper_sum_word in 63..32, bottom_sum_word in 31..0
		logic [31:0]     op_one;   // operand_one
		logic [31:0]     op_two;   // operand_two
		logic [1:0]      idx;      // latched sum_register_index
		logic            side;     // latched element side
		logic            mode;     // latched accumulation mode
		logic [31:0]     prod;     // q31 intermediate
		logic            prod_sat; // intermediate was clamped
		logic [3:0]      ouflag;   // overflow_sticky_bits
		logic [31:0]     result;   // destination word of reads
		logic            dsp_en;   // dsp resources enabled
		logic [2:0]      isa_rev;  // isa_revision_field
		logic [3:0]      status;   // sticky events
		logic [3:0]      mask;     // interrupt enables
		logic [31:0]     prdata;   // apb read data
		logic            pready;   // apb ready
		logic            pslverr;  // apb error
		logic            irq;      // interrupt level
	} state_s;

	state_s r_reg;  // registered state
	state_s r_next; // next state

	// true for every offset this slave answers
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == CMD_OFF) || (a == OPERAND_ONE_OFF) || (a == OPERAND_TWO_OFF) ||
			(a == RESULT_OFF) || (a == SPCTRL_OFF) || (a == CONFIG_OFF) ||
			(a == STATUS_OFF) || (a == MASK_OFF);
	endfunction : addr_mapped

	// read data mux, shared by the answer and the clear-on-read path
	function automatic logic [31:0] read_word(input state_s s, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h00000000;
		unique case (a)
			CMD_OFF:         w = 32'h00000000;
			OPERAND_ONE_OFF: w = s.op_one;
			OPERAND_TWO_OFF: w = s.op_two;
			RESULT_OFF:      w = s.result;
			SPCTRL_OFF:      w[OUFLAG_LSB +: 4] = s.ouflag;
			CONFIG_OFF: begin
				w[CFG_EN_BIT] = s.dsp_en;
				w[CFG_REV_LSB +: 3] = s.isa_rev;
			end
			STATUS_OFF:      w[3:0] = s.status;
			MASK_OFF:        w[3:0] = s.mask;
			default:         w = 32'h00000000;
		endcase
		return w;
	endfunction : read_word

	// command fields as presented on the bus
	logic [1:0]  cmd_idx;  // index of the command being written
	kind_e       cmd_kind; // operation group of the command
	logic        setup_ok; // access phase may be answered
	logic        complete; // transfer completes at this edge
	logic        read_chk; // accumulator read needs the access check
	logic [15:0] half_a;   // selected halfword of operand_one
	logic [15:0] half_b;   // selected halfword of operand_two
	logic [63:0] sum;      // accumulator plus sign-extended product
	logic        ovf;      // clamping overflow detected
	logic [31:0] clamp_val; // word stored in clamping mode
	logic [3:0]  st_set;   // status bits set this cycle
	logic [3:0]  st_clr;   // status bits cleared by a read

	assign cmd_idx  = pwdata[CMD_IDX_LSB +: 2];
	assign cmd_kind = kind_e'(pwdata[CMD_KIND_LSB +: 2]);
	// a command write waits for the pending accumulate; this is the interlock
	assign setup_ok = !(pwrite && paddr == CMD_OFF && r_reg.state != S_IDLE);
	assign complete = psel && penable && r_reg.pready;
	assign read_chk = (cmd_idx != 2'b00) || (r_reg.isa_rev >= REV_CHECK_MIN);
	// element side picks the halfword pair
	assign half_a = r_reg.side ? r_reg.op_one[15:0] : r_reg.op_one[31:16];
	assign half_b = r_reg.side ? r_reg.op_two[15:0] : r_reg.op_two[31:16];
	assign sum = r_reg.acc[r_reg.idx] + sext64(r_reg.prod);
	assign ovf = sum[32] != sum[31];
	// the sign of the full sum tells positive from negative overflow
	assign clamp_val = ovf ? (sum[63] ? Q31_MIN : Q31_MAX) : sum[31:0];

	// next-state logic for bus, sequencer and flags
	always_comb begin
		r_next = r_reg;
		st_set = 4'h0;
		st_clr = 4'h0;
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;

		// first access cycle: prepare the answer, raise ready one edge later
		if (psel && penable && !r_reg.pready && setup_ok) begin
			r_next.pready = 1'b1;
			r_next.pslverr = !addr_mapped(paddr);
			r_next.prdata = pwrite ? 32'h00000000 : read_word(r_reg, paddr);
		end

		// completion edge: writes take effect, status reads clear what they showed
		if (complete && !r_reg.pslverr) begin
			if (pwrite) begin
				unique case (paddr)
					CMD_OFF: begin
						unique case (cmd_kind)
							K_MAC: begin
								if (!r_reg.dsp_en) begin
									st_set[ST_DSP_OFF] = 1'b1;
								end else begin
									r_next.idx = cmd_idx;
									r_next.side = pwdata[CMD_SIDE_BIT];
									r_next.mode = pwdata[CMD_MODE_BIT];
									r_next.state = S_MUL;
								end
							end
							K_UPPER, K_BOTTOM: begin
								if (read_chk && !r_reg.dsp_en) begin
									st_set[ST_DSP_OFF] = 1'b1;
								end else begin
									// reads touch neither accumulators nor flags
									r_next.result = (cmd_kind == K_UPPER) ?
										r_reg.acc[cmd_idx][63:32] :
										r_reg.acc[cmd_idx][31:0];
									st_set[ST_DONE] = 1'b1;
								end
							end
							K_RSVD:  st_set[ST_RSVD] = 1'b1;
						endcase
					end
					OPERAND_ONE_OFF: r_next.op_one = pwdata;
					OPERAND_TWO_OFF: r_next.op_two = pwdata;
					CONFIG_OFF: begin
						r_next.dsp_en = pwdata[CFG_EN_BIT];
						r_next.isa_rev = pwdata[CFG_REV_LSB +: 3];
					end
					MASK_OFF:        r_next.mask = pwdata[3:0];
					default:         r_next.mask = r_reg.mask; // read-only words
				endcase
			end else if (paddr == STATUS_OFF) begin
				st_clr = r_reg.prdata[3:0];
			end
		end

		// datapath sequencer
		unique case (r_reg.state)
			S_IDLE: r_next.state = r_next.state;
			S_MUL: begin
				r_next.prod = fractional_halfword_product(half_a, half_b);
				r_next.prod_sat = (half_a == Q15_NEG_ONE) && (half_b == Q15_NEG_ONE);
				r_next.state = S_ACC;
			end
			S_ACC: begin
				if (r_reg.mode) begin
					r_next.acc[r_reg.idx] = sext64(clamp_val);
				end else begin
					r_next.acc[r_reg.idx] = sum;
				end
				// overflow only marks flags, never an exception
				if (r_reg.prod_sat || (r_reg.mode && ovf)) begin
					r_next.ouflag[r_reg.idx] = 1'b1;
					st_set[ST_OVF] = 1'b1;
				end
				st_set[ST_DONE] = 1'b1;
				r_next.state = S_IDLE;
			end
			default: r_next.state = S_IDLE;
		endcase

		// set wins over a clear in the same cycle
		r_next.status = (r_reg.status & ~st_clr) | st_set;
		r_next.irq = |(r_next.status & r_next.mask);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.dsp_en <= CFG_EN_RST;
			r_reg.isa_rev <= CFG_REV_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata  = r_reg.prdata;
	assign pready  = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign irq     = r_reg.irq;

	// assertion helpers
	logic signed [31:0] left_raw;  // plain product of the upper halfwords
	logic signed [31:0] right_raw; // plain product of the lower halfwords
	logic               cmd_done;  // a command write completes
	assign left_raw  = $signed(r_reg.op_one[31:16]) * $signed(r_reg.op_two[31:16]);
	assign right_raw = $signed(r_reg.op_one[15:0]) * $signed(r_reg.op_two[15:0]);
	assign cmd_done  = complete && !r_reg.pslverr && pwrite && paddr == CMD_OFF;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_left_product: assert property (
		r_reg.state == S_MUL && !r_reg.side && left_raw != 32'sh40000000
		|=> r_reg.prod == {$past(left_raw[30:0]), 1'b0})
		else $error("left product wrong");
	a_right_product: assert property (
		r_reg.state == S_MUL && r_reg.side && right_raw != 32'sh40000000
		|=> r_reg.prod == {$past(right_raw[30:0]), 1'b0})
		else $error("right product wrong");
	a_product_clamp: assert property (
		r_reg.state == S_MUL && half_a == Q15_NEG_ONE && half_b == Q15_NEG_ONE
		|=> r_reg.prod == Q31_MAX && r_reg.prod_sat)
		else $error("minus one squared not clamped");
	a_wrap_sum: assert property (
		r_reg.state == S_ACC && !r_reg.mode
		|=> r_reg.acc[$past(r_reg.idx)] == $past(sum))
		else $error("wrapping sum wrong");
	a_clamp_range: assert property (
		r_reg.state == S_ACC && r_reg.mode && ovf
		|=> r_reg.acc[$past(r_reg.idx)] == ($past(sum[63]) ? sext64(Q31_MIN) : sext64(Q31_MAX)))
		else $error("clamp value wrong");
	a_clamp_pass: assert property (
		r_reg.state == S_ACC && r_reg.mode && !ovf
		|=> r_reg.acc[$past(r_reg.idx)] == sext64($past(sum[31:0])))
		else $error("in-range clamp sum wrong");
	a_flag_set: assert property (
		r_reg.state == S_ACC && r_reg.prod_sat |=> r_reg.ouflag[$past(r_reg.idx)])
		else $error("overflow flag not set");
	a_flags_sticky: assert property (
		(r_reg.ouflag & ~$past(r_reg.ouflag)) == 4'h0 || $past(r_reg.state) == S_ACC)
		else $error("flag set outside accumulate");
	a_flags_hold: assert property (
		##1 (r_reg.ouflag & $past(r_reg.ouflag)) == $past(r_reg.ouflag))
		else $error("overflow flag cleared");
	a_acc_stable: assert property (
		r_reg.state != S_ACC |=> $stable(r_reg.acc))
		else $error("accumulator changed outside accumulate");
	a_mac_sequence: assert property (
		r_reg.state == S_MUL |=> r_reg.state == S_ACC ##1 r_reg.state == S_IDLE)
		else $error("mac sequence broken");
	a_read_interlock: assert property (
		r_reg.state != S_IDLE && psel && penable && pwrite && paddr == CMD_OFF
		|=> !r_reg.pready)
		else $error("command answered while busy");
	a_read_upper: assert property (
		cmd_done && cmd_kind == K_UPPER && (r_reg.dsp_en || !read_chk)
		|=> r_reg.result == $past(r_reg.acc[cmd_idx][63:32]))
		else $error("upper word read wrong");
	a_read_bottom: assert property (
		cmd_done && cmd_kind == K_BOTTOM && (r_reg.dsp_en || !read_chk)
		|=> r_reg.result == $past(r_reg.acc[cmd_idx][31:0]))
		else $error("bottom word read wrong");
	a_access_check: assert property (
		cmd_done && cmd_kind == K_MAC && !r_reg.dsp_en
		|=> r_reg.state == S_IDLE && r_reg.status[ST_DSP_OFF])
		else $error("disabled mac not refused");
	a_read_skip_check: assert property (
		cmd_done && cmd_kind != K_MAC && cmd_kind != K_RSVD && !read_chk
		|=> r_reg.status[ST_DONE])
		else $error("unchecked read refused");
	// the clamping overflow path marks the same per-accumulator flag
	a_clamp_flag: assert property (
		r_reg.state == S_ACC && r_reg.mode && ovf |=> r_reg.ouflag[$past(r_reg.idx)])
		else $error("clamp overflow flag not set");
	// wrapping keeps the full sum, so only the product clamp may raise a flag
	a_wrap_no_flag: assert property (
		r_reg.state == S_ACC && !r_reg.mode && !r_reg.prod_sat
		|=> r_reg.ouflag == $past(r_reg.ouflag))
		else $error("wrapping flagged without saturation");
	// the flags show in signal_proc_control as soon as they are set
	a_ouflag_visible: assert property (
		psel && penable && !r_reg.pready && !pwrite && paddr == SPCTRL_OFF
		|=> r_reg.prdata[OUFLAG_LSB +: 4] == $past(r_reg.ouflag))
		else $error("overflow flags not shown");
	// saturation is reported as a status event, never as a bus error
	a_ovf_status: assert property (
		r_reg.state == S_ACC && (r_reg.prod_sat || (r_reg.mode && ovf))
		|=> r_reg.status[ST_OVF])
		else $error("overflow event lost");
	a_no_data_error: assert property (
		r_reg.pslverr |-> !addr_mapped($past(paddr)))
		else $error("bus error on a mapped word");
	// accumulator reads are pure: no accumulator or flag moves
	a_read_no_change: assert property (
		cmd_done && (cmd_kind == K_UPPER || cmd_kind == K_BOTTOM)
		|=> $stable(r_reg.acc) && $stable(r_reg.ouflag))
		else $error("accumulator read changed state");
	// an accumulate touches only the accumulator that its index names
	for (genvar k = 0; k < 4; k++) begin : g_acc_guard
		a_acc_select: assert property (@(posedge pclk) disable iff (!presetn)
			r_reg.state == S_ACC && r_reg.idx != 2'(k) |=> $stable(r_reg.acc[k]))
			else $error("unselected accumulator changed");
	end

	c_clamp_overflow: cover property (r_reg.state == S_ACC && r_reg.mode && ovf);
	c_product_sat: cover property (r_reg.state == S_ACC && r_reg.prod_sat);
	c_stalled_read: cover property (r_reg.state == S_ACC && psel && penable && pwrite);
	c_irq_raised: cover property (!r_reg.irq ##1 r_reg.irq);
	c_mac_refused: cover property (cmd_done && cmd_kind == K_MAC && !r_reg.dsp_en);

endmodule : q15_fractional_mac_unit

`default_nettype wire

// ==== verif/apb_master_model.sv ====
// apb_master_model: pipeline side of the unit, one apb transfer per call.
// assumes xfer is called from a single process of the testbench.
`timescale 1ns/1ps
`default_nettype none

module apb_master_model (
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata,
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// setup, then access held until pready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err, output logic tmo);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		tmo = (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released lines show no stale value
		paddr  <= ~a;
		pwdata <= ~wd;
	endtask : xfer
endmodule : apb_master_model
`default_nettype wire

// ==== verif/testbench.sv ====
// testbench: random and corner multiply-accumulate traffic, checked against
// a reference accumulator model. assumes one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench
	import q15_mac_pkg::*;
;
	logic        pclk, presetn;          // clock, reset active low
	logic        psel, penable, pwrite;  // apb request
	logic [7:0]  paddr;                  // byte address
	logic [31:0] pwdata, prdata;         // data
	logic        pready, pslverr, irq;   // answers
	logic [63:0] acc_m [4];              // reference accumulators
	logic [3:0]  flag_m;                 // reference sticky flags
	logic        ovf_m;                  // reference overflow event
	int          num_errors, n_checks;   // counters

	q15_fractional_mac_unit u_q15_fractional_mac_unit (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	apb_master_model u_apb_master_model (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// 100 ns clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic end_sim;
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk1

	// one transfer; a hang ends the run
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic xerr, output logic [31:0] rd);
		logic e;
		logic tmo;
		u_apb_master_model.xfer(wr, a, wd, rd, e, tmo);
		if (tmo) begin
			num_errors++;
			$display("[ERR] %0t bus timeout", $time);
			end_sim();
		end else begin
			chk1(e, xerr, "pslverr");
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, 1'b0, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, 1'b0, x);
		chk32(x, exp, "read");
	endtask : rd

	// reference product, the minus-one squared case clamps
	function automatic logic [31:0] q15_prod(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		return (a == 16'h8000 && b == 16'h8000) ? 32'h7fffffff : p <<< 1;
	endfunction : q15_prod

	// operand halves biased toward the extremes
	function automatic logic [31:0] pick();
		logic [15:0] h [2];
		foreach (h[k]) begin
			case ($urandom_range(3))
				0: h[k] = 16'h8000;
				1: h[k] = 16'h7fff;
				default: h[k] = 16'($urandom());
			endcase
		end
		return {h[0], h[1]};
	endfunction : pick

	// updates the model, then launches the operation
	task automatic do_mac(input logic [31:0] a, input logic [31:0] b, input logic [1:0] idx,
		input logic side, input logic mode);
		logic [15:0] ha;
		logic [15:0] hb;
		logic [31:0] pr;
		logic [63:0] s;
		ha = side ? a[15:0] : a[31:16];
		hb = side ? b[15:0] : b[31:16];
		pr = q15_prod(ha, hb);
		s = acc_m[idx] + {{32{pr[31]}}, pr};
		if (ha == 16'h8000 && hb == 16'h8000) begin
			flag_m[idx] = 1'b1;
			ovf_m = 1'b1;
		end
		if (mode && s[32] != s[31]) begin
			flag_m[idx] = 1'b1;
			ovf_m = 1'b1;
			s = s[63] ? 64'hffffffff80000000 : 64'h000000007fffffff;
		end else if (mode) begin
			s = {{32{s[31]}}, s[31:0]};
		end
		acc_m[idx] = s;
		wr(OPERAND_ONE_OFF, a);
		wr(OPERAND_TWO_OFF, b);
		wr(CMD_OFF, {26'h0, 2'b00, mode, side, idx});
	endtask : do_mac

	// both words of one accumulator, then the sticky flags
	task automatic chk_acc(input logic [1:0] idx);
		wr(CMD_OFF, {26'h0, 2'b01, 2'b00, idx});
		rd(RESULT_OFF, acc_m[idx][63:32]);
		wr(CMD_OFF, {26'h0, 2'b10, 2'b00, idx});
		rd(RESULT_OFF, acc_m[idx][31:0]);
		rd(SPCTRL_OFF, {12'h0, flag_m, 16'h0});
	endtask : chk_acc

	initial begin
		logic [31:0] x;
		num_errors = 0;
		n_checks = 0;
		flag_m = 4'h0;
		ovf_m = 1'b0;
		foreach (acc_m[k]) acc_m[k] = 64'h0;
		presetn = 1'b0;
		void'($urandom(32'hc2e49fe0));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(CONFIG_OFF, {28'h0, CFG_REV_RST, CFG_EN_RST});
		rd(SPCTRL_OFF, 32'h0);
		rd(MASK_OFF, 32'h0);
		bus(1'b0, 8'h20, 32'h0, 1'b1, x);
		chk32(x, 32'h0, "unmapped");
		// corners: product clamp on the right pair, then both clamping directions
		do_mac(32'h12348000, 32'h56788000, 2'd2, 1'b1, 1'b0);
		chk_acc(2'd2);
		repeat (2) do_mac(32'h7fff0001, 32'h7fff0001, 2'd3, 1'b0, 1'b1);
		chk_acc(2'd3);
		repeat (2) do_mac(32'h80000001, 32'h7fff0001, 2'd1, 1'b0, 1'b1);
		chk_acc(2'd1);
		rd(OPERAND_ONE_OFF, 32'h80000001);
		rd(OPERAND_TWO_OFF, 32'h7fff0001);
		rd(CMD_OFF, 32'h0);
		for (int i = 0; i < 60; i++) begin
			do_mac(pick(), pick(), 2'($urandom_range(3)), 1'($urandom()), 1'($urandom()));
			chk_acc(2'($urandom_range(3)));
		end
		rd(STATUS_OFF, {30'h0, ovf_m, 1'b1});
		rd(STATUS_OFF, 32'h0);
		wr(SPCTRL_OFF, 32'h0);
		rd(SPCTRL_OFF, {12'h0, flag_m, 16'h0});
		// dsp disabled, revision 0
		wr(CONFIG_OFF, 32'h0);
		wr(OPERAND_ONE_OFF, 32'h80008000);
		wr(OPERAND_TWO_OFF, 32'h80008000);
		wr(CMD_OFF, 32'h01);
		rd(STATUS_OFF, 32'h4);
		wr(CMD_OFF, 32'h10);
		wr(RESULT_OFF, 32'hffffffff);
		rd(RESULT_OFF, acc_m[0][63:32]);
		rd(STATUS_OFF, 32'h1);
		wr(CMD_OFF, 32'h12);
		rd(STATUS_OFF, 32'h4);
		wr(CONFIG_OFF, 32'h4);
		wr(CMD_OFF, 32'h20);
		rd(STATUS_OFF, 32'h4);
		wr(CONFIG_OFF, 32'h1);
		chk_acc(2'd1);
		rd(STATUS_OFF, 32'h1);
		wr(CMD_OFF, 32'h30);
		rd(STATUS_OFF, 32'h8);
		// interrupt masked, unmasked, cleared by the status read
		wr(MASK_OFF, 32'h8);
		wr(CMD_OFF, 32'h10);
		repeat (2) @(posedge pclk);
		chk1(irq, 1'b0, "irq masked");
		wr(MASK_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk1(irq, 1'b1, "irq");
		rd(STATUS_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk1(irq, 1'b0, "irq cleared");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
